// ==== ncosd_pkg.sv ====
// package: register map, field positions and reset values of the nco datapath
package ncosd_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int ACC_W = 28;
  localparam int PH_W = 12;
  localparam int DAC_W = 10;
  localparam int TUNE_HI_W = ACC_W - 16;

  // ----------------------------------------------------------------
  // apb register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TUNE_A = 8'h04;
  localparam logic [7:0] OFS_TUNE_B = 8'h08;
  localparam logic [7:0] OFS_PHASE_A = 8'h0C;
  localparam logic [7:0] OFS_PHASE_B = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;

  // ----------------------------------------------------------------
  // control word bit positions
  // ----------------------------------------------------------------
  localparam int CTRL_W = 14;
  localparam int BIT_FREQ_CHOICE = 11;
  localparam int BIT_PHASE_CHOICE = 10;
  localparam int BIT_PIN_SELECT = 9;
  localparam int BIT_LOGIC_EN = 5;
  localparam int BIT_SRC_SEL = 4;
  localparam int BIT_MODE = 1;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [CTRL_W-1:0] CTRL_RST = 14'h0000;
  localparam logic [ACC_W-1:0] TUNE_RST = 28'h0000000;
  localparam logic [PH_W-1:0] PHASE_RST = 12'h000;
  localparam logic [ACC_W-1:0] ACC_RST = 28'h0000000;
  localparam logic [DAC_W-1:0] DAC_MID = 10'h200;

  // ----------------------------------------------------------------
  // output selection
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    NCOSD_OUT_SINE,
    NCOSD_OUT_RAMP,
    NCOSD_OUT_MSB
  } ncosd_wave_t;

  typedef struct packed {
    logic [DAC_W-1:0] dac_code;
    logic square_out;
  } ncosd_out_t;

endpackage : ncosd_pkg

// ==== ncosd_core.sv ====
// nco phase accumulator, phase modulator, sine lookup and apb registers
// Function
// RQ1: phase accumulator is 28 bits wide
// RQ2: add selected tuning word each clock, wrapping
// RQ3: tuning word chosen by pin or bit
// RQ4: word change keeps accumulator, no phase jump
// RQ5: selected phase offset added to accumulator msbs
// RQ6: two offset registers, step 1/4096 cycle
// RQ7: truncate to upper 12 bits as address
// RQ8: table maps 12-bit phase to 10-bit code
// RQ9: enable bit and mode bit steer sine table
// RQ10: comparator reaches pin when both bits set
// RQ11: source bit picks comparator or phase msb
// RQ12: reset pin clears phase, keeps registers
// RQ13: phase offset chosen by pin or bit
// RQ14: offset binary code, zero phase midscale
// RQ15: bypass in mode gives triangular ramp
//
// Implementation choices: the APB slave port and the address map.
module ncosd_core
  import ncosd_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // device pins
  input wire logic phase_reset,
  input wire logic freq_select_pin,
  input wire logic phase_select_pin,
  input wire logic comparator_input,
  output ncosd_pkg::ncosd_out_t wave_out
);
  import ncosd_pkg::*;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [CTRL_W-1:0] ctrl_word;
  logic [ACC_W-1:0] tuning_word_a;
  logic [ACC_W-1:0] tuning_word_b;
  logic [PH_W-1:0] phase_offset_a;
  logic [PH_W-1:0] phase_offset_b;
  logic [ACC_W-1:0] phase_acc;
  logic [PH_W-1:0] phase_addr;
  logic addr_valid;

  logic freq_choice_bit;
  logic phase_choice_bit;
  logic pin_select;
  logic logic_output_enable;
  logic output_source_select;
  logic mode_ramp;
  logic use_b_freq;
  logic use_b_phase;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic [ACC_W-1:0] next_acc;
  logic [PH_W-1:0] next_addr;
  logic [PH_W-1:0] acc_msb;
  ncosd_wave_t wave_sel;
  logic [31:0] next_rdata;

  assign freq_choice_bit = ctrl_word[BIT_FREQ_CHOICE];
  assign phase_choice_bit = ctrl_word[BIT_PHASE_CHOICE];
  assign pin_select = ctrl_word[BIT_PIN_SELECT];
  assign logic_output_enable = ctrl_word[BIT_LOGIC_EN];
  assign output_source_select = ctrl_word[BIT_SRC_SEL];
  assign mode_ramp = ctrl_word[BIT_MODE];

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // merge a 32-bit write into a register image under byte strobes
  function automatic logic [31:0] strb_merge(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0] st);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res;
  endfunction : strb_merge

  // register slots that the apb address can select
  typedef enum logic [2:0] {
    NCOSD_REG_CTRL,
    NCOSD_REG_TUNE_A,
    NCOSD_REG_TUNE_B,
    NCOSD_REG_PHASE_A,
    NCOSD_REG_PHASE_B,
    NCOSD_REG_STATUS,
    NCOSD_REG_NONE
  } ncosd_reg_t;

  // map a byte address onto a register slot; shared by read and write
  function automatic ncosd_reg_t decode_addr(input logic [7:0] a);
    ncosd_reg_t r;
    if (a == OFS_CTRL) begin
      r = NCOSD_REG_CTRL;
    end else if (a == OFS_TUNE_A) begin
      r = NCOSD_REG_TUNE_A;
    end else if (a == OFS_TUNE_B) begin
      r = NCOSD_REG_TUNE_B;
    end else if (a == OFS_PHASE_A) begin
      r = NCOSD_REG_PHASE_A;
    end else if (a == OFS_PHASE_B) begin
      r = NCOSD_REG_PHASE_B;
    end else if (a == OFS_STATUS) begin
      r = NCOSD_REG_STATUS;
    end else begin
      r = NCOSD_REG_NONE;
    end
    return r;
  endfunction : decode_addr

  ncosd_reg_t reg_sel;
  logic wr_ok;
  assign reg_sel = decode_addr(paddr);

  // quarter-wave sine, result in offset binary around midscale
  function automatic logic [DAC_W-1:0] sine_code(input logic [PH_W-1:0] a);
    logic [PH_W-3:0] q;
    real ang;
    int mag;
    logic [DAC_W-2:0] m;
    q = a[PH_W-2] ? ~a[PH_W-3:0] : a[PH_W-3:0];
    ang = (real'(q) + 0.5) * 3.14159265358979 / 2048.0;
    mag = int'($floor($sin(ang) * 511.0 + 0.5));
    m = mag[DAC_W-2:0];
    if (a[PH_W-1]) begin
      return DAC_MID - {1'b0, m};
    end
    return DAC_MID + {1'b0, m};
  endfunction : sine_code

  // ----------------------------------------------------------------
  // sine table
  // ----------------------------------------------------------------
  // RQ8 table of codes
  logic [DAC_W-1:0] sine_rom [0:(1<<PH_W)-1];
  generate
    for (genvar g = 0; g < (1 << PH_W); g++) begin : g_rom
      // RQ14 offset binary
      assign sine_rom[g] = sine_code(PH_W'(g));
    end
  endgenerate

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;

  always_comb begin
    addr_ok = 1'b1;
    next_rdata = 32'h00000000;
    if (reg_sel == NCOSD_REG_CTRL) begin
      next_rdata = 32'(ctrl_word);
    end else if (reg_sel == NCOSD_REG_TUNE_A) begin
      next_rdata = 32'(tuning_word_a);
    end else if (reg_sel == NCOSD_REG_TUNE_B) begin
      next_rdata = 32'(tuning_word_b);
    end else if (reg_sel == NCOSD_REG_PHASE_A) begin
      next_rdata = 32'(phase_offset_a);
    end else if (reg_sel == NCOSD_REG_PHASE_B) begin
      next_rdata = 32'(phase_offset_b);
    end else if (reg_sel == NCOSD_REG_STATUS) begin
      next_rdata = {1'b0, use_b_phase, use_b_freq, phase_acc[ACC_W-1 -: 7],
                    wave_out.dac_code, phase_addr};
    end else begin
      addr_ok = 1'b0;
    end
  end

  // zero-wait-state slave: data set up during setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      if (rd_en) begin
        prdata <= next_rdata;
      end
    end
  end

  // write lands only in the access cycle of an accepted transfer
  assign wr_ok = clk_en && wr_en && pready && !pslverr;

  // software registers; the phase reset pin never touches these
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_word <= CTRL_RST;
    end else if (wr_ok && reg_sel == NCOSD_REG_CTRL) begin
      ctrl_word <= CTRL_W'(strb_merge(32'(ctrl_word), pwdata, pstrb));
    end
  end

  // first tuning word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tuning_word_a <= TUNE_RST;
    end else if (wr_ok && reg_sel == NCOSD_REG_TUNE_A) begin
      tuning_word_a <=
        ACC_W'(strb_merge(32'(tuning_word_a), pwdata, pstrb));
    end
  end

  // second tuning word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tuning_word_b <= TUNE_RST;
    end else if (wr_ok && reg_sel == NCOSD_REG_TUNE_B) begin
      tuning_word_b <=
        ACC_W'(strb_merge(32'(tuning_word_b), pwdata, pstrb));
    end
  end

  // RQ6 offset a
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_offset_a <= PHASE_RST;
    end else if (wr_ok && reg_sel == NCOSD_REG_PHASE_A) begin
      phase_offset_a <=
        PH_W'(strb_merge(32'(phase_offset_a), pwdata, pstrb));
    end
  end

  // RQ6 offset b
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_offset_b <= PHASE_RST;
    end else if (wr_ok && reg_sel == NCOSD_REG_PHASE_B) begin
      phase_offset_b <=
        PH_W'(strb_merge(32'(phase_offset_b), pwdata, pstrb));
    end
  end

  // ----------------------------------------------------------------
  // nco
  // ----------------------------------------------------------------
  // RQ3 frequency source select
  assign use_b_freq = pin_select ? freq_select_pin : freq_choice_bit;
  // RQ13 phase source select
  assign use_b_phase = pin_select ? phase_select_pin : phase_choice_bit;

  // RQ2 modulo accumulate
  assign next_acc = phase_acc + (use_b_freq ? tuning_word_b : tuning_word_a);

  // RQ5 offset onto msbs
  assign acc_msb = phase_acc[ACC_W-1 -: PH_W];
  // RQ7 truncated address
  assign next_addr = acc_msb + (use_b_phase ? phase_offset_b : phase_offset_a);

  // RQ1 accumulator register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_acc <= ACC_RST;
    end else if (clk_en) begin
      if (phase_reset) begin
        // RQ12 clear phase only
        phase_acc <= ACC_RST;
      end else begin
        // RQ4 keep phase
        phase_acc <= next_acc;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_addr <= PHASE_RST;
      addr_valid <= 1'b0;
    end else if (clk_en) begin
      phase_addr <= phase_reset ? PHASE_RST : next_addr;
      addr_valid <= !phase_reset;
    end
  end

  // ----------------------------------------------------------------
  // output stage
  // ----------------------------------------------------------------
  always_comb begin
    // RQ9 table enable
    if (logic_output_enable) begin
      wave_sel = NCOSD_OUT_MSB;
    end else if (mode_ramp) begin
      wave_sel = NCOSD_OUT_RAMP;
    end else begin
      wave_sel = NCOSD_OUT_SINE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wave_out <= '{dac_code: DAC_MID, square_out: 1'b0};
    end else if (clk_en) begin
      case (wave_sel)
        NCOSD_OUT_SINE: begin
          wave_out.dac_code <= addr_valid ? sine_rom[phase_addr] : DAC_MID;
        end
        NCOSD_OUT_RAMP: begin
          // RQ15 triangle fold
          wave_out.dac_code <= phase_addr[PH_W-1]
            ? ~phase_addr[PH_W-2 -: DAC_W] : phase_addr[PH_W-2 -: DAC_W];
        end
        default: begin
          wave_out.dac_code <= DAC_MID;
        end
      endcase
      if (logic_output_enable && output_source_select) begin
        // RQ10 comparator route
        wave_out.square_out <= comparator_input;
      end else if (logic_output_enable) begin
        // RQ11 phase msb route
        wave_out.square_out <= phase_addr[PH_W-1];
      end else begin
        wave_out.square_out <= 1'b0;
      end
    end
  end

endmodule : ncosd_core

// ==== ncosd_assertions.sv ====
// checker: apb handshake, freeze and reset behaviour of the nco core
module ncosd_assertions
  import ncosd_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // device outputs
  input wire ncosd_pkg::ncosd_out_t wave_out
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence apb_setup;
    psel && !penable && clk_en;
  endsequence
  AST_READY_AFTER_SETUP: assert property (apb_setup |=> pready)
    else $error("no ready after setup");
  AST_READY_PULSE: assert property (pready && clk_en |=> !pready)
    else $error("ready longer than one cycle");
  AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
    else $error("ready outside access phase");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("error without ready");
  AST_ERR_UNMAPPED: assert property (
    apb_setup ##0 (paddr > 8'h14) |=> pslverr)
    else $error("unmapped access not refused");
  AST_ERR_MAPPED: assert property (
    apb_setup ##0 (paddr <= 8'h14 && paddr[1:0] == 2'h0) |=> !pslverr)
    else $error("mapped access refused");
  AST_ERR_NO_DATA: assert property (
    pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read returns data");
  AST_FREEZE: assert property (!clk_en |=> $stable(wave_out))
    else $error("outputs move while frozen");
  AST_RESET_MID: assert property ($rose(presetn) |->
    wave_out.dac_code == DAC_MID && !wave_out.square_out)
    else $error("reset output not midscale");
endmodule : ncosd_assertions

bind ncosd_core ncosd_assertions u_chk (
  .pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr,
  .prdata, .pready, .pslverr, .wave_out
);

// ==== tb_top.sv ====
// testbench: apb registers, output paths and resets of the nco core
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ncosd_pkg::*;
  logic pclk = 1'h0, presetn = 1'h0, clk_en = 1'h1, psel = 1'h0;
  logic penable = 1'h0, pwrite = 1'h0, phase_reset = 1'h0;
  logic freq_select_pin = 1'h0, phase_select_pin = 1'h0;
  logic comparator_input = 1'h0, pready, pslverr, er;
  logic [7:0] paddr = 8'h00;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] pwdata = 32'h0, prdata, rd, t;
  ncosd_out_t wave_out;
  int fails = 0, comparisons = 0;
  // ctrl, phase pin, comparator, offset a, address, dac, square
  typedef struct {
    logic [13:0] c;
    logic p, k;
    logic [11:0] o, a;
    logic [9:0] d;
    logic s;
  } ncosd_row_t;
  ncosd_row_t rows [10] = '{
    '{14'h0000, 1'h0, 1'h0, 12'h400, 12'h400, 10'h3FF, 1'h0},
    '{14'h0000, 1'h0, 1'h0, 12'hC00, 12'hC00, 10'h001, 1'h0},
    '{14'h0002, 1'h0, 1'h0, 12'h123, 12'h123, 10'h091, 1'h0},
    '{14'h0002, 1'h0, 1'h0, 12'h923, 12'h923, 10'h36E, 1'h0},
    '{14'h0020, 1'h0, 1'h0, 12'h923, 12'h923, 10'h200, 1'h1},
    '{14'h0030, 1'h0, 1'h1, 12'h123, 12'h123, 10'h200, 1'h1},
    '{14'h0030, 1'h0, 1'h0, 12'h123, 12'h123, 10'h200, 1'h0},
    '{14'h0400, 1'h0, 1'h0, 12'h400, 12'hC00, 10'h001, 1'h0},
    '{14'h0200, 1'h1, 1'h0, 12'h400, 12'hC00, 10'h001, 1'h0},
    '{14'h0200, 1'h0, 1'h0, 12'h400, 12'h400, 10'h3FF, 1'h0}};

  ncosd_core u_dut (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .phase_reset,
    .freq_select_pin, .phase_select_pin, .comparator_input, .wave_out);

  initial begin
    forever #4 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) begin
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task automatic stop_test;
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test

  initial begin
    #100000;
    fails++;
    stop_test();
  end

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    for (int i = 0; i < 5; i++) begin
      apb(1'h0, 8'(4 * i), 32'h0);
      chk(rd, 32'h0);
    end
    apb(1'h0, OFS_STATUS, 32'h0);
    chk(rd, 32'h00200000);
    apb(1'h1, OFS_PHASE_B, 32'hC00);
    foreach (rows[i]) begin
      phase_select_pin <= rows[i].p;
      comparator_input <= rows[i].k;
      apb(1'h1, OFS_PHASE_A, 32'(rows[i].o));
      apb(1'h1, OFS_CTRL, 32'(rows[i].c));
      repeat (4) @(posedge pclk);
      chk(32'(wave_out.dac_code), 32'(rows[i].d));
      chk(32'(wave_out.square_out), 32'(rows[i].s));
      apb(1'h0, OFS_STATUS, 32'h0);
      chk(32'(rd[11:0]), 32'(rows[i].a));
    end
    apb(1'h1, OFS_TUNE_A, 32'h0100000);
    apb(1'h1, OFS_TUNE_B, 32'h0200000);
    for (int i = 0; i < 4; i++) begin
      freq_select_pin <= i[0];
      apb(1'h1, OFS_CTRL, i < 2 ? 32'h200 : 32'(i[0]) << 11);
      repeat (4) @(posedge pclk);
      apb(1'h0, OFS_STATUS, 32'h0);
      t = rd;
      apb(1'h0, OFS_STATUS, 32'h0);
      chk(32'(12'(rd[11:0] - t[11:0])), i[0] ? 32'h60 : 32'h30);
    end
    phase_reset <= 1'h1;
    repeat (3) @(posedge pclk);
    apb(1'h0, OFS_STATUS, 32'h0);
    chk(rd, 32'h20200000);
    phase_reset <= 1'h0;
    apb(1'h0, OFS_TUNE_A, 32'h0);
    chk(rd, 32'h0100000);
    apb(1'h1, OFS_TUNE_B, 32'hFFFFFFFF);
    apb(1'h0, OFS_TUNE_B, 32'h0);
    chk(rd, 32'h0FFFFFFF);
    pstrb <= 4'h1;
    apb(1'h1, OFS_TUNE_A, 32'hFFFFFFFF);
    pstrb <= 4'hF;
    apb(1'h0, OFS_TUNE_A, 32'h0);
    chk(rd, 32'h01000FF);
    apb(1'h0, 8'h18, 32'h0);
    chk({er, rd[30:0]}, 32'h80000000);
    apb(1'h1, OFS_STATUS, 32'hFFFFFFFF);
    chk(32'(er), 32'h0);
    clk_en <= 1'h0;
    repeat (4) @(posedge pclk);
    clk_en <= 1'h1;
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, OFS_PHASE_B, 32'h0);
    chk(rd, 32'h0);
    stop_test();
  end
endmodule : tb_top
